// File: src/tol_axil.sv
// axi4-lite slave front end: captures one write and one read at a time
// assumes the core answers reads combinationally from its registers
`timescale 1ns/1ps
module tol_axil
  import tol_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  // axi4-lite
  input  wire logic [TOL_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [TOL_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // core side
  output logic                       wr_en,
  output logic [TOL_ADDR_W-3:0]      wr_idx,
  output logic [7:0]                 wr_data,
  input  wire logic                  wr_ok,
  output logic                       rd_en,
  output logic [TOL_ADDR_W-3:0]      rd_idx,
  input  wire logic [31:0]           rd_data,
  input  wire logic                  rd_ok
);
  logic                  aw_reg, aw_next, w_reg, w_next, b_reg, b_next;
  logic                  ar_reg, ar_next, r_reg, r_next;
  logic [TOL_ADDR_W-3:0] awi_reg, awi_next, ari_reg, ari_next;
  logic [7:0]            wd_reg, wd_next;
  logic [1:0]            br_reg, br_next, rr_reg, rr_next;
  logic [31:0]           rd_reg, rd_next;
  // lane-0 strobe of the held beat; an empty strobe must not replay old data
  logic                  ws_reg, ws_next, wfire;
  // ready flags registered so every bus output leaves a flop
  logic                  awr_reg, awr_next, wrr_reg, wrr_next, arr_reg, arr_next;

  assign wfire  = aw_reg & w_reg & ~b_reg;
  assign wr_en  = wfire & ws_reg;
  assign wr_idx = awi_reg;
  assign wr_data = wd_reg;
  assign rd_en  = ar_reg & ~r_reg;
  assign rd_idx = ari_reg;

  // channel handshakes; address and data taken in either order
  always_comb
  begin
    aw_next = aw_reg; w_next = w_reg; b_next = b_reg; awi_next = awi_reg;
    wd_next = wd_reg; br_next = br_reg; ar_next = ar_reg; r_next = r_reg;
    ari_next = ari_reg; rr_next = rr_reg; rd_next = rd_reg; ws_next = ws_reg;
    if (s_axi_awvalid && !aw_reg && !b_reg)
    begin
      aw_next  = 1'b1;
      awi_next = s_axi_awaddr[TOL_ADDR_W-1:2];
    end
    if (s_axi_wvalid && !w_reg && !b_reg)
    begin
      w_next  = 1'b1;
      // byte lane 0 only; the registers are a byte wide
      wd_next = s_axi_wdata[7:0];
      ws_next = s_axi_wstrb[0];
    end
    if (wfire)
    begin
      aw_next = 1'b0;
      w_next  = 1'b0;
      b_next  = 1'b1;
      br_next = wr_ok ? TOL_RESP_OKAY : TOL_RESP_SLVERR;
    end
    if (b_reg && s_axi_bready)
      b_next = 1'b0;
    if (s_axi_arvalid && !ar_reg && !r_reg)
    begin
      ar_next  = 1'b1;
      ari_next = s_axi_araddr[TOL_ADDR_W-1:2];
    end
    if (rd_en)
    begin
      ar_next = 1'b0;
      r_next  = 1'b1;
      rd_next = rd_ok ? rd_data : 32'h0;
      rr_next = rd_ok ? TOL_RESP_OKAY : TOL_RESP_SLVERR;
    end
    if (r_reg && s_axi_rready)
      r_next = 1'b0;
    awr_next = ~aw_next & ~b_next;
    wrr_next = ~w_next & ~b_next;
    arr_next = ~ar_next & ~r_next;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_reg <= 1'b0; w_reg <= 1'b0; b_reg <= 1'b0; ar_reg <= 1'b0; r_reg <= 1'b0;
      awi_reg <= '0; ari_reg <= '0; wd_reg <= 8'h0; br_reg <= TOL_RESP_OKAY;
      rr_reg <= TOL_RESP_OKAY; rd_reg <= 32'h0;
      ws_reg <= 1'b0; awr_reg <= 1'b1; wrr_reg <= 1'b1; arr_reg <= 1'b1;
    end
    else if (ce)
    begin
      aw_reg <= aw_next; w_reg <= w_next; b_reg <= b_next; ar_reg <= ar_next; r_reg <= r_next;
      awi_reg <= awi_next; ari_reg <= ari_next; wd_reg <= wd_next; br_reg <= br_next;
      rr_reg <= rr_next; rd_reg <= rd_next;
      ws_reg <= ws_next; awr_reg <= awr_next; wrr_reg <= wrr_next; arr_reg <= arr_next;
    end
  end

  assign s_axi_awready = awr_reg;
  assign s_axi_wready  = wrr_reg;
  assign s_axi_bvalid  = b_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid  = r_reg;
  assign s_axi_rresp   = rr_reg;
  assign s_axi_rdata   = rd_reg;
endmodule // tol_axil

// File: src/tol_pkg.sv
// package for the triggered output latch: register map, fields, reset values
// assumes an axi4-lite master with 32-bit data; one aligned word per register
//
// Function
// - The output count is fixed at build time to 48, 32 or 16, and groups past the count are absent.
// - The outputs form six byte groups, each written on its own as one byte.
// - Outputs go out as three pairs of sixteen, the trigger input arriving with the first pair.
// - Software selects immediate or external trigger update mode.
// - In immediate mode a written byte reaches its outputs at once.
// - In trigger mode writes go to a buffer and leave the outputs alone.
// - In trigger mode a rising trigger edge copies the whole buffer to the outputs.
// - Several writes between rising edges leave only the last value to be copied.
// - In trigger mode with the option set, a falling trigger edge clears both buffer and outputs.
// - A rising edge with no write since the last transfer counts as an underrun.
// - A second write before a rising edge after the first write flags overflow.
// - A readable bit shows that a rising edge occurred; software polls it before rewriting.
// - Reset forces every output off.
// - Offsets 0,1,2,4,5,6 are write-only output bytes; offset 3 is trigger control and status.
// - The window base sits on an eight-byte boundary.
package tol_pkg;
  localparam int          TOL_NUM_OUTPUTS = 48;
  localparam int          TOL_NUM_GROUPS  = 6;
  localparam int          TOL_ADDR_W      = 8;
  localparam int          TOL_CNT_W       = 8;
  // printed offsets are not multiples of four: indices, byte address = 4*index
  localparam logic [2:0]  TOL_IDX_G0      = 3'h0;
  localparam logic [2:0]  TOL_IDX_G1      = 3'h1;
  localparam logic [2:0]  TOL_IDX_G2      = 3'h2;
  localparam logic [2:0]  TOL_IDX_TRIG    = 3'h3;
  localparam logic [2:0]  TOL_IDX_G3      = 3'h4;
  localparam logic [2:0]  TOL_IDX_G4      = 3'h5;
  localparam logic [2:0]  TOL_IDX_G5      = 3'h6;
  // extra registers placed by index
  localparam logic [3:0]  TOL_IDX_IRQ_ST  = 4'h8;
  localparam logic [3:0]  TOL_IDX_IRQ_MSK = 4'h9;
  localparam logic [3:0]  TOL_IDX_UNDCNT  = 4'ha;
  // trigger control fields (write)
  localparam int          TOL_CTL_MODE    = 0;
  localparam int          TOL_CTL_FALLCLR = 1;
  localparam int          TOL_CTL_CLRCNT  = 2;
  // trigger status fields (read)
  localparam int          TOL_ST_TRIG     = 0;
  localparam int          TOL_ST_OVF      = 1;
  localparam int          TOL_ST_UND      = 2;
  // interrupt status bits
  localparam int          TOL_IRQ_RISE    = 0;
  localparam int          TOL_IRQ_OVF     = 1;
  localparam int          TOL_IRQ_UND     = 2;
  localparam int          TOL_IRQ_W       = 3;
  localparam logic [1:0]  TOL_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  TOL_RESP_SLVERR = 2'h2;
  localparam logic [47:0] TOL_OUT_OFF     = 48'h0;
endpackage

// File: src/tol_sync.sv
// two-flop synchroniser and edge detector for the external trigger
// assumes trig_pin is asynchronous to aclk
`timescale 1ns/1ps
module tol_sync
  import tol_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // pin and edges
  input  wire logic trig_pin,
  output logic      rise,
  output logic      fall
);
  logic s1_reg, s1_next, s2_reg, s2_next, s3_reg, s3_next;

  // next state; s1 is read only by s2
  always_comb
  begin
    s1_next = trig_pin;
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else if (ce)
    begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  assign rise = s2_reg & ~s3_reg;
  assign fall = ~s2_reg & s3_reg;
endmodule // tol_sync

// File: src/tol_top.sv
// triggered output latch: six output bytes, trigger buffer, error tracking
// assumes an axi4-lite master on aclk and an asynchronous trigger pin
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module tol_top
  import tol_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  // axi4-lite
  input  wire logic [TOL_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [TOL_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // trigger pin, carried with the first group pair
  input  wire logic                  ext_trigger,
  // output group pairs
  output logic [15:0]                first_output_group_pair,
  output logic [15:0]                second_output_group_pair,
  output logic [15:0]                third_output_group_pair,
  // interrupt
  output logic                       irq
);
  // ==========================================================
  // sub-blocks
  logic                  wr_en, rd_en, rise, fall;
  logic [TOL_ADDR_W-3:0] wr_idx, rd_idx;
  logic [7:0]            wr_data;
  logic [31:0]           rd_data;
  logic                  wr_ok, rd_ok;

  tol_axil u_axil (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .wr_ok(wr_ok),
    .rd_en(rd_en), .rd_idx(rd_idx), .rd_data(rd_data), .rd_ok(rd_ok)
  );

  tol_sync u_sync (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .trig_pin(ext_trigger), .rise(rise), .fall(fall)
  );

  // ==========================================================
  // address decode
  // map a register index to an output group, or -1
  function automatic int group_of(input logic [TOL_ADDR_W-3:0] idx);
    case (idx)
      {3'h0, TOL_IDX_G0}: group_of = 0;
      {3'h0, TOL_IDX_G1}: group_of = 1;
      {3'h0, TOL_IDX_G2}: group_of = 2;
      {3'h0, TOL_IDX_G3}: group_of = 3;
      {3'h0, TOL_IDX_G4}: group_of = 4;
      {3'h0, TOL_IDX_G5}: group_of = 5;
      default:            group_of = -1;
    endcase
  endfunction

  function automatic logic group_present(input int g);
    group_present = (g >= 0) && (g * 8 < TOL_NUM_OUTPUTS);
  endfunction

  // ==========================================================
  // state
  logic [47:0]          buf_reg, buf_next, out_reg, out_next;
  logic                 mode_reg, mode_next, fclr_reg, fclr_next;
  logic                 trig_reg, trig_next, ovf_reg, ovf_next, und_reg, und_next;
  logic                 pend_reg, pend_next;
  logic [TOL_CNT_W-1:0] cnt_reg, cnt_next;
  logic [TOL_IRQ_W-1:0] ist_reg, ist_next, msk_reg, msk_next, ev;
  logic                 irq_reg, irq_next;
  int                   wg;

  // the whole index is compared; upper index bits must be zero to reach a register
  always_comb
  begin
    wg    = group_of(wr_idx);
    wr_ok = group_present(wg) || wr_idx == {3'h0, TOL_IDX_TRIG} ||
            wr_idx == {2'h0, TOL_IDX_IRQ_ST} || wr_idx == {2'h0, TOL_IDX_IRQ_MSK};
    rd_ok = rd_idx == {3'h0, TOL_IDX_TRIG} || rd_idx == {2'h0, TOL_IDX_IRQ_ST} ||
            rd_idx == {2'h0, TOL_IDX_IRQ_MSK} || rd_idx == {2'h0, TOL_IDX_UNDCNT};
    // read map: status at offset 3
    rd_data = 32'h0;
    if (rd_idx == {3'h0, TOL_IDX_TRIG})
    begin
      rd_data[TOL_ST_TRIG]     = trig_reg;
      rd_data[TOL_ST_OVF]      = ovf_reg;
      rd_data[TOL_ST_UND]      = und_reg;
      rd_data[TOL_CTL_MODE+8]  = mode_reg;
      rd_data[TOL_CTL_FALLCLR+8] = fclr_reg;
    end
    else if (rd_idx == {2'h0, TOL_IDX_IRQ_ST})
      rd_data[TOL_IRQ_W-1:0] = ist_reg;
    else if (rd_idx == {2'h0, TOL_IDX_IRQ_MSK})
      rd_data[TOL_IRQ_W-1:0] = msk_reg;
    else if (rd_idx == {2'h0, TOL_IDX_UNDCNT})
      rd_data[TOL_CNT_W-1:0] = cnt_reg;
  end

  // main next-state logic
  always_comb
  begin
    logic gw;
    gw = wr_en && group_present(wg);
    buf_next = buf_reg; out_next = out_reg; mode_next = mode_reg; fclr_next = fclr_reg;
    trig_next = trig_reg; ovf_next = ovf_reg; und_next = und_reg; pend_next = pend_reg;
    cnt_next = cnt_reg; msk_next = msk_reg; ev = '0;
    if (gw)
    begin
      buf_next[wg*8 +: 8] = wr_data;
      if (!mode_reg)
        out_next[wg*8 +: 8] = wr_data;
      else
      begin
        if (pend_reg && !trig_reg)
        begin
          ovf_next = 1'b1;
          ev[TOL_IRQ_OVF] = 1'b1;
        end
        pend_next = 1'b1;
        // new write rearms the occurred bit
        trig_next = 1'b0;
      end
    end
    if (wr_en && wr_idx == {3'h0, TOL_IDX_TRIG})
    begin
      mode_next = wr_data[TOL_CTL_MODE];
      fclr_next = wr_data[TOL_CTL_FALLCLR];
      if (wr_data[TOL_CTL_CLRCNT])
      begin
        cnt_next = '0;
        ovf_next = 1'b0;
        und_next = 1'b0;
      end
    end
    if (wr_en && wr_idx == {2'h0, TOL_IDX_IRQ_MSK})
      msk_next = wr_data[TOL_IRQ_W-1:0];
    // trigger edges; edge handling follows writes so same-cycle flags survive
    if (mode_reg && rise)
    begin
      out_next = gw ? buf_next : buf_reg;
      trig_next = 1'b1;
      ev[TOL_IRQ_RISE] = 1'b1;
      if (!pend_reg && !gw)
      begin
        und_next = 1'b1;
        ev[TOL_IRQ_UND] = 1'b1;
        if (cnt_reg != {TOL_CNT_W{1'b1}})
          cnt_next = cnt_reg + 1'b1;
      end
      pend_next = 1'b0;
    end
    if (mode_reg && fclr_reg && fall)
    begin
      buf_next = TOL_OUT_OFF;
      out_next = TOL_OUT_OFF;
    end
    // interrupt status: set wins over write-one-to-clear
    ist_next = ist_reg;
    if (wr_en && wr_idx == {2'h0, TOL_IDX_IRQ_ST})
      ist_next = ist_reg & ~wr_data[TOL_IRQ_W-1:0];
    ist_next = ist_next | ev;
    irq_next = |(ist_next & msk_next);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      buf_reg <= TOL_OUT_OFF; out_reg <= TOL_OUT_OFF;
      mode_reg <= 1'b0; fclr_reg <= 1'b0; trig_reg <= 1'b0;
      ovf_reg <= 1'b0; und_reg <= 1'b0; pend_reg <= 1'b0;
      cnt_reg <= '0; ist_reg <= '0; msk_reg <= '0; irq_reg <= 1'b0;
    end
    else if (ce)
    begin
      buf_reg <= buf_next; out_reg <= out_next;
      mode_reg <= mode_next; fclr_reg <= fclr_next; trig_reg <= trig_next;
      ovf_reg <= ovf_next; und_reg <= und_next; pend_reg <= pend_next;
      cnt_reg <= cnt_next; ist_reg <= ist_next; msk_reg <= msk_next; irq_reg <= irq_next;
    end
  end

  assign first_output_group_pair  = out_reg[15:0];
  assign second_output_group_pair = out_reg[31:16];
  assign third_output_group_pair  = out_reg[47:32];
  assign irq = irq_reg;
endmodule // tol_top

// File: testbench/test_tol_top.sv
// self-checking bench for tol_top: bus tasks, trigger model, checker bind
// assumes the trigger model pulses wide enough to pass the synchroniser
`timescale 1ns/1ps
module test_tol_top
  import tol_pkg::*;
;
  logic        aclk, aresetn, ce, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        ext_trigger;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] p0, p1, p2;
  logic [47:0] exp_out;
  logic [3:0]  gidx [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
  logic [7:0]  gval [6] = '{8'h11, 8'h22, 8'h44, 8'h88, 8'h0f, 8'hf0};
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;
  tol_trig_src src (.aclk(aclk), .ext_trigger(ext_trigger));
  tol_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ext_trigger(ext_trigger), .first_output_group_pair(p0),
    .second_output_group_pair(p1), .third_output_group_pair(p2), .irq(irq));
  always #10 aclk = ~aclk;
  // =====================================================
  // compare and bus tasks
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_out(input logic [47:0] e);
    n_compared++;
    if ({p2, p1, p0} !== e)
    begin
      err_total++;
      $display("mismatch outputs expected %h seen %h", e, {p2, p1, p0});
    end
  endtask
  // write one byte, wait for the answer, check its code
  task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic aw_d, w_d, fin;
    aw_d = 1'b0;
    w_d = 1'b0;
    fin = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!fin)
    begin
      @(posedge aclk);
      if (!aw_d && s_axi_awready)
      begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_d && s_axi_wready)
      begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid)
      begin
        fin = 1'b1;
        s_axi_bready <= 1'b0;
        chk_val("write resp", {30'h0, er}, {30'h0, s_axi_bresp});
      end
    end
  endtask
  // read one word, compare the masked bits and the answer code
  task automatic rd(input logic [3:0] idx, input logic [31:0] msk, input logic [31:0] e, input logic [1:0] er);
    logic fin;
    fin = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!fin)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        fin = 1'b1;
        s_axi_rready <= 1'b0;
        chk_val("read data", e, s_axi_rdata & msk);
        chk_val("read resp", {30'h0, er}, {30'h0, s_axi_rresp});
      end
    end
  endtask
  // hang guard: a few thousand cycles of pulses plus margin
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total++;
      finish_test();
    end
  end
  // =====================================================
  // main sequence
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'h1;
    exp_out = TOL_OUT_OFF;
    repeat (16) @(posedge aclk);
    chk_out(TOL_OUT_OFF);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_out(TOL_OUT_OFF);
    // immediate mode: each group lands on its own byte
    for (int i = 0; i < 6; i++)
    begin
      wr(gidx[i], gval[i], TOL_RESP_OKAY);
      exp_out[8*i +: 8] = gval[i];
      repeat (2) @(posedge aclk);
      chk_out(exp_out);
    end
    rd(4'h0, 32'hffffffff, 32'h0, TOL_RESP_SLVERR);
    rd(4'hb, 32'hffffffff, 32'h0, TOL_RESP_SLVERR);
    wr(4'h7, 8'hff, TOL_RESP_SLVERR);
    // empty lane-0 strobe: answered, but nothing written
    s_axi_wstrb <= 4'h0;
    wr(4'h1, 8'hee, TOL_RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    chk_out(exp_out);
    $display("test immediate done");
    // trigger mode: buffered writes, overflow, transfer on rise
    wr(4'h9, 8'h07, TOL_RESP_OKAY);
    wr(4'h3, 8'h01, TOL_RESP_OKAY);
    rd(4'h3, 32'h300, 32'h100, TOL_RESP_OKAY);
    wr(4'h0, 8'ha5, TOL_RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk_out(exp_out);
    wr(4'h0, 8'h3c, TOL_RESP_OKAY);
    rd(4'h3, 32'h2, 32'h2, TOL_RESP_OKAY);
    chk_val("irq", 32'h1, {31'h0, irq});
    src.pulse(6);
    exp_out[7:0] = 8'h3c;
    chk_out(exp_out);
    rd(4'h3, 32'h1, 32'h1, TOL_RESP_OKAY);
    rd(4'ha, 32'hff, 32'h0, TOL_RESP_OKAY);
    src.pulse(6);
    chk_out(exp_out);
    rd(4'ha, 32'hff, 32'h1, TOL_RESP_OKAY);
    rd(4'h3, 32'h4, 32'h4, TOL_RESP_OKAY);
    $display("test trigger done");
    // interrupt: clear, mask, unmask
    wr(4'h8, 8'h07, TOL_RESP_OKAY);
    rd(4'h8, 32'h7, 32'h0, TOL_RESP_OKAY);
    chk_val("irq", 32'h0, {31'h0, irq});
    wr(4'h9, 8'h00, TOL_RESP_OKAY);
    src.pulse(6);
    rd(4'h8, 32'h4, 32'h4, TOL_RESP_OKAY);
    chk_val("irq", 32'h0, {31'h0, irq});
    wr(4'h9, 8'h04, TOL_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_val("irq", 32'h1, {31'h0, irq});
    wr(4'h8, 8'h07, TOL_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_val("irq", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    // falling edge clears outputs and buffer
    wr(4'h3, 8'h03, TOL_RESP_OKAY);
    rd(4'h3, 32'h1, 32'h1, TOL_RESP_OKAY);
    wr(4'h1, 8'h5a, TOL_RESP_OKAY);
    src.drive(1'b1);
    repeat (8) @(posedge aclk);
    exp_out[15:8] = 8'h5a;
    chk_out(exp_out);
    src.drive(1'b0);
    repeat (8) @(posedge aclk);
    chk_out(TOL_OUT_OFF);
    src.pulse(6);
    chk_out(TOL_OUT_OFF);
    $display("test fall clear done");
    // count clears on command then saturates
    wr(4'h3, 8'h05, TOL_RESP_OKAY);
    rd(4'ha, 32'hff, 32'h0, TOL_RESP_OKAY);
    for (int i = 0; i < 260; i++)
      src.pulse(6);
    rd(4'ha, 32'hff, 32'hff, TOL_RESP_OKAY);
    $display("test saturation done");
    // enable low freezes the block: a pulse then leaves no trace
    wr(4'h2, 8'h77, TOL_RESP_OKAY);
    ce <= 1'b0;
    src.pulse(6);
    ce <= 1'b1;
    repeat (4) @(posedge aclk);
    chk_out(TOL_OUT_OFF);
    src.pulse(6);
    chk_out({24'h0, 8'h77, 16'h0});
    // reset in mid-run drops lit outputs, the count and the mode
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk_out(TOL_OUT_OFF);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(4'ha, 32'hff, 32'h0, TOL_RESP_OKAY);
    rd(4'h3, 32'h300, 32'h0, TOL_RESP_OKAY);
    $display("test enable and reset done");
    finish_test();
  end
endmodule // test_tol_top

bind tol_top tol_top_sva u_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ext_trigger(ext_trigger), .first_output_group_pair(first_output_group_pair),
  .second_output_group_pair(second_output_group_pair), .third_output_group_pair(third_output_group_pair));

// File: testbench/tol_top_sva.sv
// checker for tol_top: bus answer timing, reset state, output stability
// assumes it is bound to tol_top and sees only that module's ports
`timescale 1ns/1ps
module tol_top_sva
  import tol_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // pin and outputs
  input wire logic        ext_trigger,
  input wire logic [15:0] first_output_group_pair,
  input wire logic [15:0] second_output_group_pair,
  input wire logic [15:0] third_output_group_pair
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [47:0] outs;
  logic [3:0]  quiet_reg;
  logic [3:0]  quiet_next;
  logic        trig_reg;
  logic        trig_next;
  assign outs = {third_output_group_pair, second_output_group_pair, first_output_group_pair};
  // cycles since the pin moved or a data beat landed, saturating so it never wraps
  always_comb
  begin
    trig_next  = ext_trigger;
    quiet_next = (quiet_reg == 4'hf) ? quiet_reg : quiet_reg + 4'h1;
    if (!aresetn || ext_trigger != trig_reg || (s_axi_wvalid && s_axi_wready))
      quiet_next = 4'h0;
  end
  always_ff @(posedge aclk)
  begin
    quiet_reg <= quiet_next;
    trig_reg  <= trig_next;
  end
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_reset_outs_off: assert property (disable iff (1'b0) !aresetn |=> outs == TOL_OUT_OFF)
    else $error("outputs not off after a reset edge");
  a_write_resp_time: assert property (s_wr_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_resp_time: assert property (s_rd_take |-> ##2 s_axi_rvalid)
    else $error("read response late");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_no_take_pending: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_refused_read_zero: assert property (s_axi_rvalid && s_axi_rresp == TOL_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  a_outs_quiet: assert property (quiet_reg >= 4'h8 |-> $stable(outs))
    else $error("outputs moved with no write and no trigger");
endmodule // tol_top_sva

// File: testbench/tol_trig_src.sv
// trigger source model: drives the external trigger pin for the bench
// assumes aclk is the bench clock; the pin moves just after a rising edge
`timescale 1ns/1ps
module tol_trig_src
(
  // clock
  input wire logic aclk,
  // trigger pin
  output logic     ext_trigger
);
  initial ext_trigger = 1'b0;
  // level change, held until the next call
  task automatic drive(input logic v);
    @(posedge aclk);
    ext_trigger <= v;
  endtask
  task automatic pulse(input int n);
    drive(1'b1);
    repeat (n) @(posedge aclk);
    drive(1'b0);
    repeat (n) @(posedge aclk);
  endtask
endmodule // tol_trig_src
